// File: dv/cmpoc_analog_model.sv
// Behavioural comparator facing the block
`timescale 1ns/100ps
module cmpoc_analog_model
(
    input wire logic clk_i,
    input wire logic enable_i,
    input wire logic level_i,
    output logic raw_o = 1'b0
);
    // Follows the level while enabled; a powered-off one wanders
    always @(posedge clk_i)
    begin
        raw_o <= enable_i ? level_i : ~raw_o;
    end
endmodule // cmpoc_analog_model

// File: dv/cmpoc_properties.sv
// Checker of bus and register behaviour at the block ports
`timescale 1ns/100ps
module cmpoc_properties
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cmp_a_enable_o,
    input wire logic cmp_b_enable_o,
    input wire logic [1:0] cmp_a_neg_input_select_o,
    input wire logic [1:0] cmp_b_pos_input_select_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic take;
    logic wr;
    logic [7:0] idx;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = take & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    a_ack_next: assert property (take |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_unmapped_read: assert property (take && !wb_we_i && idx == 8'h90 |=>
        wb_dat_o == '0)
        else $error("unmapped read not zero");
    a_enable_write: assert property (wr && idx == cmpoc_pkg::ENABLE_IDX |=>
        cmp_a_enable_o == $past(wb_dat_i[0]) && cmp_b_enable_o == $past(wb_dat_i[4]))
        else $error("enable not stored");
    a_enable_cause: assert property ($changed({cmp_a_enable_o, cmp_b_enable_o}) |->
        $past(wr && idx == cmpoc_pkg::ENABLE_IDX))
        else $error("enable moved alone");
    a_insel_write: assert property (wr && idx == cmpoc_pkg::INSEL_IDX |=>
        {cmp_b_pos_input_select_o, cmp_a_neg_input_select_o} ==
        $past({wb_dat_i[7:6], wb_dat_i[1:0]}))
        else $error("input select not stored");
    a_mask_quiet: assert property (wr && idx == cmpoc_pkg::IRQ_MASK_IDX
        && !wb_dat_i[0] |=> !irq_o)
        else $error("masked interrupt high");
endmodule // cmpoc_properties
bind cmpoc_top cmpoc_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .cmp_a_enable_o(cmp_a_enable_o), .cmp_b_enable_o(cmp_b_enable_o),
    .cmp_a_neg_input_select_o(cmp_a_neg_input_select_o),
    .cmp_b_pos_input_select_o(cmp_b_pos_input_select_o));

// File: dv/testbench.sv
// Self-checking bench for the comparator output control block
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, cmp_a_raw_i, cmp_b_raw_i, en_a, en_b, pa, pb, sa, sb, irq_o;
    logic [1:0] ap, an, bp, bn;
    logic la = 1'b0;
    logic lb = 1'b0;
    logic [7:0] rdata, d;
    int err_count = 0;
    int compares = 0;
    int seed = 32'hbe34;
    always #25 clk_i = ~clk_i;
    cmpoc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_a_raw_i, .cmp_b_raw_i, .cmp_a_enable_o(en_a),
        .cmp_b_enable_o(en_b), .cmp_a_pos_input_select_o(ap), .cmp_a_neg_input_select_o(an),
        .cmp_b_pos_input_select_o(bp), .cmp_b_neg_input_select_o(bn), .cmp_a_pin_o(pa),
        .cmp_b_pin_o(pb), .cmp_a_sense_o(sa), .cmp_b_sense_o(sb), .irq_o);
    cmpoc_analog_model u_a (.clk_i, .enable_i(en_a), .level_i(la), .raw_o(cmp_a_raw_i));
    cmpoc_analog_model u_b (.clk_i, .enable_i(en_b), .level_i(lb), .raw_o(cmp_b_raw_i));
    // ========================================
    // Model, bus and check tasks
    function automatic int lut_bit(int code, int own, int other);
        return (code >> (2 * (1 - own) + 1 - other)) & 1;
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic acc(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h00_0000, wd};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
        acc(1'b0, idx, 8'h00);
        check(name, rdata, exp);
    endtask
    task automatic settle;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic lv(input logic a, input logic b);
        @(posedge clk_i);
        la <= a;
        lb <= b;
        settle;
    endtask
    task automatic test_done;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        err_count++;
        test_done;
    end
    // ========================================
    // Scenarios
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) rd(cmpoc_pkg::STATUS_IDX + 8'(i), 8'h00, "reset");
        rd(8'h90, 8'h00, "unmapped");
        d = 8'($random(seed));
        acc(1'b1, cmpoc_pkg::INSEL_IDX, d);
        rd(cmpoc_pkg::INSEL_IDX, d, "insel");
        check("insel pins", {bp, bn, ap, an}, d);
        acc(1'b1, cmpoc_pkg::ENABLE_IDX, 8'h11);
        rd(cmpoc_pkg::ENABLE_IDX, 8'h11, "enable");
        acc(1'b1, cmpoc_pkg::ENABLE_IDX, 8'h00);
        lv(1'b1, 1'b1);
        rd(cmpoc_pkg::STATUS_IDX, 8'h00, "disabled");
        acc(1'b1, cmpoc_pkg::ENABLE_IDX, 8'h11);
        settle;
        rd(cmpoc_pkg::STATUS_IDX, 8'h33, "live");
        lv(1'b0, 1'b0);
        rd(cmpoc_pkg::STATUS_IDX, 8'h03, "sticky");
        acc(1'b1, cmpoc_pkg::STATUS_IDX, 8'h03);
        rd(cmpoc_pkg::STATUS_IDX, 8'h03, "write one");
        acc(1'b1, cmpoc_pkg::STATUS_IDX, 8'h02);
        rd(cmpoc_pkg::STATUS_IDX, 8'h02, "soft clear");
        acc(1'b1, cmpoc_pkg::LUT_IDX, 8'hc3);
        acc(1'b1, cmpoc_pkg::OUTCFG_IDX, 8'h20);
        acc(1'b1, cmpoc_pkg::STATUS_IDX, 8'h00);
        rd(cmpoc_pkg::STATUS_IDX, 8'h02, "write ignored");
        lv(1'b1, 1'b0);
        rd(cmpoc_pkg::STATUS_IDX, 8'h11, "edge clear");
        lv(1'b0, 1'b0);
        check("fn route", {4'h0, pb, pa, sb, sa}, 8'h0a);
        acc(1'b1, cmpoc_pkg::OUTCFG_IDX, 8'h75);
        settle;
        check("latch route", {4'h0, pb, pa, sb, sa}, 8'h05);
        acc(1'b1, cmpoc_pkg::OUTCFG_IDX, 8'h02);
        acc(1'b1, cmpoc_pkg::LUT_IDX, 8'h33);
        lv(1'b0, 1'b1);
        rd(cmpoc_pkg::STATUS_IDX, 8'h22, "edge clear a");
        acc(1'b1, cmpoc_pkg::OUTCFG_IDX, 8'h00);
        lv(1'b1, 1'b0);
        repeat (6)
        begin
            d = 8'($random(seed));
            acc(1'b1, cmpoc_pkg::LUT_IDX, d);
            settle;
            check("fn code a", {7'h00, pa}, 8'(lut_bit(d[3:0], 1, 0)));
            check("fn code b", {7'h00, pb}, 8'(lut_bit(d[7:4], 0, 1)));
        end
        lv(1'b0, 1'b0);
        acc(1'b1, cmpoc_pkg::LUT_IDX, 8'h33);
        acc(1'b1, cmpoc_pkg::OUTCFG_IDX, 8'h88);
        acc(1'b1, cmpoc_pkg::IRQ_STATUS_IDX, 8'h01);
        acc(1'b1, cmpoc_pkg::IRQ_MASK_IDX, 8'h01);
        settle;
        check("irq idle", {7'h00, irq_o}, 8'h00);
        lv(1'b0, 1'b1);
        check("irq edge", {7'h00, irq_o}, 8'h01);
        acc(1'b1, cmpoc_pkg::IRQ_STATUS_IDX, 8'h01);
        settle;
        check("irq clear", {7'h00, irq_o}, 8'h00);
        acc(1'b1, cmpoc_pkg::IRQ_MASK_IDX, 8'h00);
        lv(1'b1, 1'b1);
        check("irq masked", {7'h00, irq_o}, 8'h00);
        acc(1'b1, cmpoc_pkg::IRQ_MASK_IDX, 8'h01);
        settle;
        check("irq unmask", {7'h00, irq_o}, 8'h01);
        test_done;
    end
endmodule // testbench

// File: hdl/cmpoc_pkg.sv
// Package of constants for the comparator output control block
package cmpoc_pkg;
    // ========================================
    // Register indices (byte address = 4 * index)
    localparam logic [7:0] STATUS_IDX = 8'h78;
    localparam logic [7:0] INSEL_IDX = 8'h79;
    localparam logic [7:0] ENABLE_IDX = 8'h7a;
    localparam logic [7:0] OUTCFG_IDX = 8'h7b;
    localparam logic [7:0] LUT_IDX = 8'h7c;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h80;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h81;
    // ========================================
    // Field positions
    localparam int B_LIVE_POS = 5;
    localparam int A_LIVE_POS = 4;
    localparam int B_LATCH_POS = 1;
    localparam int A_LATCH_POS = 0;
    localparam int B_IRQ_CONNECT_POS = 7;
    localparam int B_PIN_SEL_POS = 6;
    localparam int B_CLR_SRC_POS = 5;
    localparam int B_DATA_SEL_POS = 4;
    localparam int A_IRQ_CONNECT_POS = 3;
    localparam int A_PIN_SEL_POS = 2;
    localparam int A_CLR_SRC_POS = 1;
    localparam int A_DATA_SEL_POS = 0;
    localparam int B_ENABLE_POS = 4;
    localparam int A_ENABLE_POS = 0;
    localparam int B_POS_SEL_LSB = 6;
    localparam int B_NEG_SEL_LSB = 4;
    localparam int A_POS_SEL_LSB = 2;
    localparam int A_NEG_SEL_LSB = 0;
    localparam int B_LUT_LSB = 4;
    localparam int A_LUT_LSB = 0;
    localparam int IRQ_ANALOG_POS = 0;
    // ========================================
    // Reset values and masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ENABLE_MASK = 8'h11;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h01;
endpackage

// File: hdl/cmpoc_top.sv
// Comparator output control: registers, latches, logic functions, interrupt
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
module cmpoc_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmp_a_raw_i,
    input wire logic cmp_b_raw_i,
    output logic cmp_a_enable_o,
    output logic cmp_b_enable_o,
    output logic [1:0] cmp_a_pos_input_select_o,
    output logic [1:0] cmp_a_neg_input_select_o,
    output logic [1:0] cmp_b_pos_input_select_o,
    output logic [1:0] cmp_b_neg_input_select_o,
    output logic cmp_a_pin_o,
    output logic cmp_b_pin_o,
    output logic cmp_a_sense_o,
    output logic cmp_b_sense_o,
    output logic irq_o
);
    // ========================================
    // Registers
    logic [7:0] insel_reg;
    logic [7:0] enable_reg;
    logic [7:0] outcfg_reg;
    logic [7:0] lut_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic a_latch_reg;
    logic b_latch_reg;
    logic [2:0] a_sync_reg;
    logic [2:0] b_sync_reg;
    logic a_live_reg;
    logic b_live_reg;
    logic a_func_prev_reg;
    logic b_func_prev_reg;
    logic a_data_prev_reg;
    logic b_data_prev_reg;

    // ========================================
    // Bus decode
    logic req;
    logic wr;
    logic [7:0] idx;
    logic wr_lane0;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign idx = wb_adr_i[9:2];
    assign wr_lane0 = wr && wb_sel_i[0];

    // ========================================
    // Synchronisers: change accepted when stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_sync_reg <= 3'h0;
            b_sync_reg <= 3'h0;
        end
        else
        begin
            a_sync_reg <= {a_sync_reg[1:0], cmp_a_raw_i};
            b_sync_reg <= {b_sync_reg[1:0], cmp_b_raw_i};
        end
    end

    // Stage one may be metastable, so it is never compared
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_live_reg <= 1'b0;
            b_live_reg <= 1'b0;
        end
        else
        begin
            if (a_sync_reg[1] == a_sync_reg[2])
            begin
                a_live_reg <= a_sync_reg[2];
            end
            if (b_sync_reg[1] == b_sync_reg[2])
            begin
                b_live_reg <= b_sync_reg[2];
            end
        end
    end

    // Disabled comparator reads zero
    logic a_state;
    logic b_state;
    assign a_state = a_live_reg && enable_reg[cmpoc_pkg::A_ENABLE_POS];
    assign b_state = b_live_reg && enable_reg[cmpoc_pkg::B_ENABLE_POS];

    // ========================================
    // Logic functions: x is own comparator, y the other
    // Bit 0 is both high, bit 3 both low
    function automatic logic lut_eval(input logic [3:0] code, input logic x, input logic y);
        lut_eval = code[{~x, ~y}];
    endfunction
    logic a_func;
    logic b_func;
    // Codes: 0h false, Fh true, 1h and, 3h own, 5h other, 6h xor
    assign a_func = lut_eval(lut_reg[cmpoc_pkg::A_LUT_LSB +: 4], a_state, b_state);
    assign b_func = lut_eval(lut_reg[cmpoc_pkg::B_LUT_LSB +: 4], b_state, a_state);
    logic a_func_rise;
    logic b_func_rise;
    assign a_func_rise = a_func && !a_func_prev_reg;
    assign b_func_rise = b_func && !b_func_prev_reg;

    // ========================================
    // Latches
    logic a_sw_clr;
    logic b_sw_clr;
    logic a_clr;
    logic b_clr;
    assign a_sw_clr = wr_lane0 && idx == cmpoc_pkg::STATUS_IDX
        && !wb_dat_i[cmpoc_pkg::A_LATCH_POS];
    assign b_sw_clr = wr_lane0 && idx == cmpoc_pkg::STATUS_IDX
        && !wb_dat_i[cmpoc_pkg::B_LATCH_POS];
    assign a_clr = outcfg_reg[cmpoc_pkg::A_CLR_SRC_POS] ? b_func_rise : a_sw_clr;
    assign b_clr = outcfg_reg[cmpoc_pkg::B_CLR_SRC_POS] ? a_func_rise : b_sw_clr;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_latch_reg <= 1'b0;
            b_latch_reg <= 1'b0;
        end
        else
        begin
            a_latch_reg <= a_state || (a_latch_reg && !a_clr);
            b_latch_reg <= b_state || (b_latch_reg && !b_clr);
        end
    end

    // ========================================
    // Output selection
    logic a_data;
    logic b_data;
    assign a_data = outcfg_reg[cmpoc_pkg::A_DATA_SEL_POS] ? a_latch_reg : a_func;
    assign b_data = outcfg_reg[cmpoc_pkg::B_DATA_SEL_POS] ? b_latch_reg : b_func;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_func_prev_reg <= 1'b0;
            b_func_prev_reg <= 1'b0;
            a_data_prev_reg <= 1'b0;
            b_data_prev_reg <= 1'b0;
        end
        else
        begin
            a_func_prev_reg <= a_func;
            b_func_prev_reg <= b_func;
            a_data_prev_reg <= a_data;
            b_data_prev_reg <= b_data;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmp_a_pin_o <= 1'b0;
            cmp_b_pin_o <= 1'b0;
            cmp_a_sense_o <= 1'b0;
            cmp_b_sense_o <= 1'b0;
        end
        else
        begin
            cmp_a_pin_o <= outcfg_reg[cmpoc_pkg::A_PIN_SEL_POS] ? a_latch_reg : a_func;
            cmp_b_pin_o <= outcfg_reg[cmpoc_pkg::B_PIN_SEL_POS] ? b_latch_reg : b_func;
            cmp_a_sense_o <= a_data;
            cmp_b_sense_o <= b_data;
        end
    end

    // ========================================
    // Analog interrupt event: rising edge of any connected data path
    logic irq_event;
    assign irq_event =
        (outcfg_reg[cmpoc_pkg::A_IRQ_CONNECT_POS] && a_data && !a_data_prev_reg) ||
        (outcfg_reg[cmpoc_pkg::B_IRQ_CONNECT_POS] && b_data && !b_data_prev_reg);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status_reg <= cmpoc_pkg::REG_RESET;
        end
        else
        begin
            // Set wins over write-one-to-clear
            irq_status_reg[cmpoc_pkg::IRQ_ANALOG_POS] <= irq_event ||
                (irq_status_reg[cmpoc_pkg::IRQ_ANALOG_POS] &&
                 !(wr_lane0 && idx == cmpoc_pkg::IRQ_STATUS_IDX &&
                   wb_dat_i[cmpoc_pkg::IRQ_ANALOG_POS]));
        end
    end
    assign irq_o = |(irq_status_reg & irq_mask_reg);

    // ========================================
    // Configuration writes (reserved bits forced to zero)
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            insel_reg <= cmpoc_pkg::REG_RESET;
            enable_reg <= cmpoc_pkg::REG_RESET;
            outcfg_reg <= cmpoc_pkg::REG_RESET;
            lut_reg <= cmpoc_pkg::REG_RESET;
            irq_mask_reg <= cmpoc_pkg::REG_RESET;
        end
        else if (wr_lane0)
        begin
            unique case (idx)
                cmpoc_pkg::INSEL_IDX: insel_reg <= wb_dat_i[7:0];
                cmpoc_pkg::ENABLE_IDX:
                    enable_reg <= wb_dat_i[7:0] & cmpoc_pkg::ENABLE_MASK;
                cmpoc_pkg::OUTCFG_IDX: outcfg_reg <= wb_dat_i[7:0];
                cmpoc_pkg::LUT_IDX: lut_reg <= wb_dat_i[7:0];
                cmpoc_pkg::IRQ_MASK_IDX: irq_mask_reg <= wb_dat_i[7:0] & cmpoc_pkg::IRQ_MASK_BITS;
                default: ;
            endcase
        end
    end

    assign cmp_a_enable_o = enable_reg[cmpoc_pkg::A_ENABLE_POS];
    assign cmp_b_enable_o = enable_reg[cmpoc_pkg::B_ENABLE_POS];
    assign cmp_a_pos_input_select_o = insel_reg[cmpoc_pkg::A_POS_SEL_LSB +: 2];
    assign cmp_b_pos_input_select_o = insel_reg[cmpoc_pkg::B_POS_SEL_LSB +: 2];
    assign cmp_a_neg_input_select_o = insel_reg[cmpoc_pkg::A_NEG_SEL_LSB +: 2];
    assign cmp_b_neg_input_select_o = insel_reg[cmpoc_pkg::B_NEG_SEL_LSB +: 2];

    // ========================================
    // Read data and acknowledge
    logic [7:0] status_view;
    always_comb
    begin
        status_view = 8'h00;
        status_view[cmpoc_pkg::B_LIVE_POS] = b_state;
        status_view[cmpoc_pkg::A_LIVE_POS] = a_state;
        status_view[cmpoc_pkg::B_LATCH_POS] = b_latch_reg;
        status_view[cmpoc_pkg::A_LATCH_POS] = a_latch_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
        end
    end

    // Read data stands only in the ack cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i)
            begin
                unique case (idx)
                    cmpoc_pkg::STATUS_IDX: wb_dat_o[7:0] <= status_view;
                    cmpoc_pkg::INSEL_IDX: wb_dat_o[7:0] <= insel_reg;
                    cmpoc_pkg::ENABLE_IDX: wb_dat_o[7:0] <= enable_reg;
                    cmpoc_pkg::OUTCFG_IDX: wb_dat_o[7:0] <= outcfg_reg;
                    cmpoc_pkg::LUT_IDX: wb_dat_o[7:0] <= lut_reg;
                    cmpoc_pkg::IRQ_STATUS_IDX: wb_dat_o[7:0] <= irq_status_reg;
                    cmpoc_pkg::IRQ_MASK_IDX: wb_dat_o[7:0] <= irq_mask_reg;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // cmpoc_top
